// *** src/busr_pkg.sv ***
package busr_pkg;

	localparam int STAGES = 4;
	localparam int BUF_DEPTH = 2;

	localparam logic [STAGES-1:0] STAGE_RESET = 4'h0;

	// stage positions: stage one is bit 0, stage four is bit 3
	localparam int FIRST_STAGE = 0;
	localparam int LAST_STAGE = 3;

	// mode one-hot codes
	typedef enum logic [3:0] {
		BUSR_HOLD = 4'h1,
		BUSR_RIGHT = 4'h2,
		BUSR_LEFT = 4'h4,
		BUSR_LOAD = 4'h8
	} busr_mode_t;

endpackage

// *** src/busr_strm_if.sv ***
`timescale 1ns/1ns
interface busr_strm_if #(
	parameter int WIDTH = 4
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src (
		output valid,
		output data,
		input ready
	);

	modport snk (
		input valid,
		input data,
		output ready
	);
endinterface

// *** src/busr_buf.sv ***
`timescale 1ns/1ns
module busr_buf
	import busr_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	busr_strm_if.snk wr,
	busr_strm_if.src rd
);

	initial begin
		if (DEPTH < 2 || WIDTH < 1) begin
			$error("busr_buf: depth below two or zero width");
		end
	end

	logic [WIDTH-1:0] ent [DEPTH];
	logic [DEPTH-1:0] filled;
	logic [WIDTH-1:0] next_ent [DEPTH];
	logic [DEPTH-1:0] next_filled;
	logic [WIDTH-1:0] ent_ext [DEPTH+1];
	logic [DEPTH:0] fill_ext;
	logic pop;
	logic push;

	assign wr.ready = ~filled[DEPTH-1];
	assign rd.valid = filled[0];
	assign rd.data = ent[0];
	assign pop = filled[0] & rd.ready;
	assign push = wr.valid & ~filled[DEPTH-1];

	// head shifts down on pop, new word lands in first free slot
	always_comb begin
		fill_ext = {1'b0, filled};
		for (int i = 0; i < DEPTH; i++) begin
			ent_ext[i] = ent[i];
		end
		ent_ext[DEPTH] = '0;
		for (int i = 0; i < DEPTH; i++) begin
			next_filled[i] = pop ? fill_ext[i+1] : filled[i];
			next_ent[i] = pop ? ent_ext[i+1] : ent[i];
		end
		for (int i = DEPTH-1; i >= 0; i--) begin
			if (push && !next_filled[i] && (i == 0 || next_filled[i-1])) begin
				next_ent[i] = wr.data;
			end
		end
		for (int i = DEPTH-1; i >= 0; i--) begin
			if (push && !next_filled[i] && (i == 0 || next_filled[i-1])) begin
				next_filled[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filled <= '0;
		end else if (clk_en) begin
			filled <= next_filled;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				ent[i] <= '0;
			end
		end else if (clk_en) begin
			for (int i = 0; i < DEPTH; i++) begin
				ent[i] <= next_ent[i];
			end
		end
	end

endmodule // busr_buf

// *** src/busr_shift_reg.sv ***
// Function
// - both mode selects high: all four parallel inputs load on the edge unless the snapshot buffer is full
// - loaded values appear on outputs only after the rising edge
// - during parallel load both serial inputs are ignored
// - low select only: first stage takes right serial, others previous
// - right shift moves data from stage one toward stage four
// - high select only: fourth stage takes left serial, others next
// - left shift moves data from stage four toward stage one
// - both selects low: stages keep their present values
// - low clear forces all stages and stage outputs low at once; the snapshot buffer keeps its entries
// - every stage is shown on its own output in every mode
`timescale 1ns/1ns
module busr_shift_reg
	import busr_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic clear_n,
	input wire logic mode_sel_low,
	input wire logic mode_sel_high,
	input wire logic [STAGES-1:0] par_in,
	input wire logic ser_right,
	input wire logic ser_left,
	output logic stage_one_out,
	output logic stage_two_out,
	output logic stage_three_out,
	output logic stage_four_out,
	output logic snap_valid,
	output logic [STAGES-1:0] snap_data,
	input wire logic snap_ready
);

	initial begin
		if (DEPTH < 2) begin
			$error("busr_shift_reg: snapshot buffer needs two entries");
		end
	end

	function automatic busr_mode_t mode_decode(input logic hi, input logic lo);
		busr_mode_t m;
		case ({hi, lo})
			2'b11: m = BUSR_LOAD;
			2'b01: m = BUSR_RIGHT;
			2'b10: m = BUSR_LEFT;
			default: m = BUSR_HOLD;
		endcase
		return m;
	endfunction

	busr_strm_if #(.WIDTH(STAGES)) snap_wr ();
	busr_strm_if #(.WIDTH(STAGES)) snap_rd ();

	logic [STAGES-1:0] stage;
	logic [STAGES-1:0] next_stage;
	busr_mode_t mode;
	logic clr_n;
	logic step;

	// clear acts with no clock
	assign clr_n = rst_n & clear_n;
	assign mode = mode_decode(mode_sel_high, mode_sel_low);

	always_comb begin
		case (mode)
			BUSR_LOAD: next_stage = par_in;
			BUSR_RIGHT: begin
				next_stage = {stage[LAST_STAGE-1:FIRST_STAGE], ser_right};
			end
			BUSR_LEFT: begin
				next_stage = {ser_left, stage[LAST_STAGE:FIRST_STAGE+1]};
			end
			default: next_stage = stage;
		endcase
	end

	// a changing edge waits while the snapshot buffer is full
	assign step = clk_en && mode != BUSR_HOLD && snap_wr.ready;
	assign snap_wr.valid = clk_en && mode != BUSR_HOLD && clr_n;
	assign snap_wr.data = next_stage;

	always_ff @(posedge clk or negedge clr_n) begin
		if (!clr_n) begin
			stage <= STAGE_RESET;
		end else if (step) begin
			stage <= next_stage;
		end
	end

	// outputs are the stage flops themselves
	assign stage_one_out = stage[0];
	assign stage_two_out = stage[1];
	assign stage_three_out = stage[2];
	assign stage_four_out = stage[3];

	busr_buf #(
		.WIDTH(STAGES),
		.DEPTH(DEPTH)
	) u_snap_buf (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.wr(snap_wr.snk),
		.rd(snap_rd.src)
	);

	assign snap_rd.ready = snap_ready;
	assign snap_valid = snap_rd.valid;
	assign snap_data = snap_rd.data;

endmodule // busr_shift_reg

// *** dv/busr_snap_sink.sv ***
`timescale 1ns/1ns
module busr_snap_sink (
	input wire logic clk,
	input wire logic stall,
	output logic snap_ready = 1'b0
);
	// stalls the snapshot stream from the clock after stall goes high until the clock after it falls
	always @(posedge clk) snap_ready <= !stall;
endmodule // busr_snap_sink

// *** dv/busr_shift_reg_properties.sv ***
`timescale 1ns/1ns
module busr_shift_reg_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear_n,
	input wire logic mode_sel_low,
	input wire logic mode_sel_high,
	input wire logic [3:0] par_in,
	input wire logic ser_right,
	input wire logic ser_left,
	input wire logic stage_one_out,
	input wire logic stage_two_out,
	input wire logic stage_three_out,
	input wire logic stage_four_out,
	input wire logic snap_valid,
	input wire logic [3:0] snap_data,
	input wire logic snap_ready
);
	wire [3:0] q = {stage_four_out, stage_three_out, stage_two_out,
		stage_one_out};
	wire [1:0] m = {mode_sel_high, mode_sel_low};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ld; clear_n && m == 2'h3 && !snap_valid |=> !clear_n ||
		q == $past(par_in); endproperty
	a_ld: assert property (p_ld) else $error("load");
	property p_rt; $past(m == 2'h1 && clear_n) && clear_n &&
		($changed(q) || $past(!snap_valid)) |->
		q == {$past(q[2:0]), $past(ser_right)}; endproperty
	a_rt: assert property (p_rt) else $error("right");
	property p_lf; $past(m == 2'h2 && clear_n) && clear_n &&
		($changed(q) || $past(!snap_valid)) |->
		q == {$past(ser_left), $past(q[3:1])}; endproperty
	a_lf: assert property (p_lf) else $error("left");
	property p_hd; $past(m == 2'h0) && clear_n |-> $stable(q); endproperty
	a_hd: assert property (p_hd) else $error("hold");
	property p_cl; !clear_n |-> q == 4'h0; endproperty
	a_cl: assert property (p_cl) else $error("clear");
	property p_rs; $rose(clear_n) |-> q == 4'h0; endproperty
	a_rs: assert property (p_rs) else $error("release");
	property p_st; snap_valid && !snap_ready |=> $stable(snap_data); endproperty
	a_st: assert property (p_st) else $error("stand");
	property p_sd; $rose(snap_valid) |-> snap_data == q; endproperty
	a_sd: assert property (p_sd) else $error("head");
	c_rt: cover property (m == 2'h1);
	c_lf: cover property (m == 2'h2);
	c_fl: cover property (snap_valid && !snap_ready);
endmodule // busr_shift_reg_properties
bind busr_shift_reg busr_shift_reg_properties u_props (
	.clk(clk),
	.rst_n(rst_n),
	.clear_n(clear_n),
	.mode_sel_low(mode_sel_low),
	.mode_sel_high(mode_sel_high),
	.par_in(par_in),
	.ser_right(ser_right),
	.ser_left(ser_left),
	.stage_one_out(stage_one_out),
	.stage_two_out(stage_two_out),
	.stage_three_out(stage_three_out),
	.stage_four_out(stage_four_out),
	.snap_valid(snap_valid),
	.snap_data(snap_data),
	.snap_ready(snap_ready)
);

// *** dv/test_bidir_universal_shift_reg.sv ***
`timescale 1ns/1ns
module test_bidir_universal_shift_reg;
	logic clk = 0, rst_n = 0, clear_n = 1, stall = 0, snap_ready, snap_valid;
	logic mode_sel_low = 0, mode_sel_high = 0, ser_right = 0, ser_left = 0;
	logic stage_one_out, stage_two_out, stage_three_out, stage_four_out;
	logic [3:0] par_in = 4'h0, snap_data;
	int bad_count = 0, total_checks = 0;
	wire [3:0] q = {stage_four_out, stage_three_out, stage_two_out,
		stage_one_out};
	initial forever #5 clk = ~clk;
	busr_shift_reg u_dut (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(1'b1),
		.clear_n(clear_n),
		.mode_sel_low(mode_sel_low),
		.mode_sel_high(mode_sel_high),
		.par_in(par_in),
		.ser_right(ser_right),
		.ser_left(ser_left),
		.stage_one_out(stage_one_out),
		.stage_two_out(stage_two_out),
		.stage_three_out(stage_three_out),
		.stage_four_out(stage_four_out),
		.snap_valid(snap_valid),
		.snap_data(snap_data),
		.snap_ready(snap_ready)
	);
	busr_snap_sink u_sink (
		.clk(clk),
		.stall(stall),
		.snap_ready(snap_ready)
	);
	task chk(string n, logic [3:0] e, g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task give_verdict;
		$display("checks %0d bad %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic op(logic [1:0] m, s, logic [3:0] p, e);
		{mode_sel_high, mode_sel_low} <= m;
		{ser_left, ser_right} <= s;
		par_in <= p;
		@(posedge clk);
		fork #1 chk("q", e, q); join_none
	endtask
	task t_modes;
		op(2'h3, 2'h3, 4'ha, 4'ha);
		op(2'h1, 2'h1, 4'hf, 4'h5);
		op(2'h1, 2'h2, 4'hf, 4'ha);
		op(2'h2, 2'h2, 4'h0, 4'hd);
		op(2'h2, 2'h1, 4'h0, 4'h6);
		op(2'h0, 2'h3, 4'h9, 4'h6);
		@(posedge clk);
		clear_n <= 0;
		#1 chk("q", 4'h0, q);
		@(posedge clk);
		clear_n <= 1;
	endtask
	task t_stall;
		stall <= 1;
		@(posedge clk);
		op(2'h3, 2'h0, 4'h1, 4'h1);
		op(2'h3, 2'h0, 4'h2, 4'h2);
		op(2'h3, 2'h0, 4'h3, 4'h2);
		#1 chk("head", 4'h1, snap_data);
		@(posedge clk);
		stall <= 0;
		{mode_sel_high, mode_sel_low} <= 2'h0;
		repeat (4) @(posedge clk);
		#1 chk("valid", 4'h0, {3'h0, snap_valid});
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		t_modes;
		t_stall;
		give_verdict;
	end
	initial begin
		#2000 bad_count++;
		give_verdict;
	end
endmodule // test_bidir_universal_shift_reg
